// *** rtl/prthf_top.v ***
// ring fill threshold check, drop counting and instruction range filter, apb registers
// assumes a record writer on the same clock that pulses RECORD_STORED_I after each record store
`timescale 1ns/1ps
`include "prthf_regs.vh"

module prthf_top #(
   parameter RECORD_SIZE = 32,
   parameter THR_SUPPORTED = 1,
   parameter RANGE_SUPPORTED = 1
) (
   input wire CLOCK_I,
   input wire RESET_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [7:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output wire PREADY_O,
   output wire PSLVERR_O,
   output reg [31:0] PRDATA_O,
   input wire RECORD_STORED_I,
   input wire EVENT_VALID_I,
   input wire [31:0] EVENT_CLASS_I,
   input wire [63:0] EVENT_ADDR_I,
   output reg EVENT_COUNT_O,
   output reg [31:0] RING_WRITE_OFFSET_O,
   output reg IRQ_O
);

   // register state
   reg [31:0] fill_threshold_q;
   reg [31:0] event_filter_select_q;
   reg [63:0] range_low_limit_q;
   reg [63:0] range_high_limit_q;
   reg [31:0] ring_read_offset_q;
   reg [31:0] ring_size_bytes_q;
   reg [`PRTHF_CTL_BITS-1:0] control_q;
   reg [63:0] dropped_record_count_q;
   reg [`PRTHF_IRQ_BITS-1:0] irq_status_q;
   reg [`PRTHF_IRQ_BITS-1:0] irq_mask_q;
   reg [31:0] next_offset_d;
   reg [31:0] occupancy_d;
   reg [31:0] thr_eff_d;
   reg [`PRTHF_IRQ_BITS-1:0] irq_set_d;
   reg [31:0] rdata_d;
   reg addr_ok_d;
   wire wr_stb;
   wire rd_stb;
   wire thr_active;
   wire range_active;
   wire in_range;
   wire class_ok;

   // round a byte count down to a whole number of records
   function [31:0] round_rec;
      input [31:0] val;
      begin
         round_rec = val - (val % RECORD_SIZE);
      end
   endfunction

   // ring distance from b up to a, wrapping at size
   function [31:0] ring_dist;
      input [31:0] a;
      input [31:0] b;
      input [31:0] size;
      begin
         // [R19] wrap by adding size
         if (a >= b)
            ring_dist = a - b;
         else
            ring_dist = a - b + size;
      end
   endfunction

   // zero wait states: every access ends in its first access cycle
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = 1'b0;
   assign wr_stb = PSEL_I & PENABLE_I & PWRITE_I;
   assign rd_stb = PSEL_I & ~PENABLE_I & ~PWRITE_I;

   // [R7] gate on capability and enable
   assign thr_active = (THR_SUPPORTED != 0) & control_q[`PRTHF_CTL_THR_EN];
   // [R11] limits only when filtering on
   assign range_active = (RANGE_SUPPORTED != 0) & control_q[`PRTHF_CTL_RANGE_EN];
   // [R9] low limit inclusive
   // [R10] high limit inclusive
   assign in_range = ~range_active |
      ((EVENT_ADDR_I >= range_low_limit_q) & (EVENT_ADDR_I <= range_high_limit_q));
   // [R8] class must be selected by filter
   assign class_ok = |(EVENT_CLASS_I & event_filter_select_q);

   // advance, occupancy and threshold evaluation
   always @*
   begin
      // [R12] read offset locates oldest record
      next_offset_d = RING_WRITE_OFFSET_O + RECORD_SIZE;
      if (next_offset_d >= ring_size_bytes_q)
         next_offset_d = 32'h0000_0000;
      // [R2] occupancy modulo ring size
      occupancy_d = ring_dist(next_offset_d, ring_read_offset_q, ring_size_bytes_q);
      // [R6] unsigned, rounded to records
      thr_eff_d = round_rec(fill_threshold_q);
      irq_set_d = {`PRTHF_IRQ_BITS{1'b0}};
      if (RECORD_STORED_I)
      begin
         // [R17] [R18] equal offsets would mean empty, so drop instead
         if (next_offset_d == ring_read_offset_q)
            irq_set_d[`PRTHF_IRQ_DROPPED] = 1'b1;
         // [R1] [R3] [R4] [R5] compare on each advance
         else if (thr_active && thr_eff_d <= ring_size_bytes_q && occupancy_d >= thr_eff_d)
            irq_set_d[`PRTHF_IRQ_THRESHOLD] = 1'b1;
      end
   end

   // read decode; software-use bytes and reserved words read zero
   always @*
   begin
      rdata_d = `PRTHF_RESET_WORD;
      addr_ok_d = 1'b1;
      case (PADDR_I)
         `PRTHF_FILL_THRESHOLD: rdata_d = fill_threshold_q;
         `PRTHF_EVENT_FILTER_SELECT: rdata_d = event_filter_select_q;
         `PRTHF_RANGE_LOW_LO: rdata_d = range_low_limit_q[31:0];
         `PRTHF_RANGE_LOW_HI: rdata_d = range_low_limit_q[63:32];
         `PRTHF_RANGE_HIGH_LO: rdata_d = range_high_limit_q[31:0];
         `PRTHF_RANGE_HIGH_HI: rdata_d = range_high_limit_q[63:32];
         `PRTHF_RING_READ_OFFSET: rdata_d = ring_read_offset_q;
         `PRTHF_RING_SIZE: rdata_d = ring_size_bytes_q;
         `PRTHF_RING_WRITE_OFFSET: rdata_d = RING_WRITE_OFFSET_O;
         `PRTHF_CONTROL: rdata_d = {{(32-`PRTHF_CTL_BITS){1'b0}}, control_q};
         `PRTHF_DROPPED_LO: rdata_d = dropped_record_count_q[31:0];
         `PRTHF_DROPPED_HI: rdata_d = dropped_record_count_q[63:32];
         `PRTHF_IRQ_STATUS: rdata_d = {{(32-`PRTHF_IRQ_BITS){1'b0}}, irq_status_q};
         `PRTHF_IRQ_MASK: rdata_d = {{(32-`PRTHF_IRQ_BITS){1'b0}}, irq_mask_q};
         default: addr_ok_d = 1'b0;
      endcase
      if (!addr_ok_d)
         rdata_d = `PRTHF_RESET_WORD;
   end

   // register writes, ring pointer and counters
   always @(posedge CLOCK_I)
   begin
      if (RESET_I)
      begin
         fill_threshold_q <= `PRTHF_RESET_WORD;
         event_filter_select_q <= `PRTHF_RESET_WORD;
         range_low_limit_q <= 64'h0000_0000_0000_0000;
         range_high_limit_q <= `PRTHF_RESET_HIGH_LIMIT;
         ring_read_offset_q <= `PRTHF_RESET_WORD;
         ring_size_bytes_q <= `PRTHF_RESET_WORD;
         control_q <= {`PRTHF_CTL_BITS{1'b0}};
         dropped_record_count_q <= 64'h0000_0000_0000_0000;
         irq_status_q <= {`PRTHF_IRQ_BITS{1'b0}};
         irq_mask_q <= {`PRTHF_IRQ_BITS{1'b0}};
         RING_WRITE_OFFSET_O <= `PRTHF_RESET_WORD;
         PRDATA_O <= `PRTHF_RESET_WORD;
         EVENT_COUNT_O <= 1'b0;
         IRQ_O <= 1'b0;
      end
      else
      begin
         // sample read data in setup so it is stable in access
         if (rd_stb)
            PRDATA_O <= rdata_d;
         // [R15] no write path for software-use words
         if (wr_stb)
         begin
            case (PADDR_I)
               `PRTHF_FILL_THRESHOLD: fill_threshold_q <= PWDATA_I;
               `PRTHF_EVENT_FILTER_SELECT: event_filter_select_q <= PWDATA_I;
               `PRTHF_RANGE_LOW_LO: range_low_limit_q[31:0] <= PWDATA_I;
               `PRTHF_RANGE_LOW_HI: range_low_limit_q[63:32] <= PWDATA_I;
               `PRTHF_RANGE_HIGH_LO: range_high_limit_q[31:0] <= PWDATA_I;
               `PRTHF_RANGE_HIGH_HI: range_high_limit_q[63:32] <= PWDATA_I;
               // [R13] [R14] taken as written, not checked
               `PRTHF_RING_READ_OFFSET: ring_read_offset_q <= PWDATA_I;
               `PRTHF_RING_SIZE: ring_size_bytes_q <= round_rec(PWDATA_I);
               `PRTHF_CONTROL: control_q <= PWDATA_I[`PRTHF_CTL_BITS-1:0];
               `PRTHF_IRQ_MASK: irq_mask_q <= PWDATA_I[`PRTHF_IRQ_BITS-1:0];
               default: ;
            endcase
         end
         // write offset: software may reload it, a stored record advances it
         if (RECORD_STORED_I)
         begin
            // [R18] full ring keeps offset and counts
            if (next_offset_d == ring_read_offset_q)
               dropped_record_count_q <= dropped_record_count_q + 64'h0000_0000_0000_0001;
            else
               RING_WRITE_OFFSET_O <= next_offset_d;
         end
         else if (wr_stb && PADDR_I == `PRTHF_RING_WRITE_OFFSET)
            RING_WRITE_OFFSET_O <= (PWDATA_I >= ring_size_bytes_q) ? 32'h0000_0000 : round_rec(PWDATA_I);
         // sticky status: a set in the clearing cycle wins
         if (wr_stb && PADDR_I == `PRTHF_IRQ_STATUS)
            irq_status_q <= (irq_status_q & ~PWDATA_I[`PRTHF_IRQ_BITS-1:0]) | irq_set_d;
         else
            irq_status_q <= irq_status_q | irq_set_d;
         IRQ_O <= |((irq_status_q | irq_set_d) & irq_mask_q &
            ~((wr_stb && PADDR_I == `PRTHF_IRQ_STATUS) ? PWDATA_I[`PRTHF_IRQ_BITS-1:0] & ~irq_set_d : 2'b00));
         // [R8] [R9] [R10] qualified event strobe
         EVENT_COUNT_O <= EVENT_VALID_I & class_ok & in_range;
      end
   end

endmodule

// *** rtl/prthf_regs.vh ***
// register offsets, field positions, reset values for the ring threshold / range filter block
// assumes an apb slave with 32-bit data, byte addresses, one aligned word per register
// Overview of operation
// [R1] check threshold on every write offset advance
// [R2] occupancy is write minus read modulo size
// [R3] interrupt when occupancy at or above threshold
// [R4] threshold above ring size never interrupts
// [R5] zero threshold interrupts on every record
// [R6] threshold unsigned, rounded down to record multiple
// [R7] ignore threshold unless available and enabled
// [R8] filter field qualifies which events count
// [R9] in range needs address at or above low
// [R10] in range needs address at or below high
// [R11] limits ignored if filter disabled or unsupported
// [R12] read offset is byte offset of oldest
// [R13] software keeps read offset aligned and below size
// [R14] bad read offset may misdetect overflow or threshold
// [R15] software-use bytes never read or written
// [R16] software zeroes gap before event specifiers
// [R17] ring empty when write equals read offset
// [R18] full advance keeps offset, counts dropped record
// [R19] occupancy is difference, plus size if negative
`ifndef PRTHF_REGS_VH
`define PRTHF_REGS_VH

`define PRTHF_FILL_THRESHOLD 8'h20
`define PRTHF_EVENT_FILTER_SELECT 8'h24
`define PRTHF_RANGE_LOW_LO 8'h28
`define PRTHF_RANGE_LOW_HI 8'h2c
`define PRTHF_RANGE_HIGH_LO 8'h30
`define PRTHF_RANGE_HIGH_HI 8'h34
`define PRTHF_RSVD_A_LO 8'h38
`define PRTHF_RSVD_A_HI 8'h3c
`define PRTHF_RING_READ_OFFSET 8'h40
`define PRTHF_RSVD_B 8'h44
`define PRTHF_SW_AREA_FIRST 8'h48
`define PRTHF_SW_AREA_LAST 8'h54
`define PRTHF_RING_SIZE 8'h60
`define PRTHF_RING_WRITE_OFFSET 8'h64
`define PRTHF_CONTROL 8'h68
`define PRTHF_DROPPED_LO 8'h6c
`define PRTHF_DROPPED_HI 8'h70
`define PRTHF_IRQ_STATUS 8'h74
`define PRTHF_IRQ_MASK 8'h78

`define PRTHF_CTL_THR_EN 0
`define PRTHF_CTL_RANGE_EN 1
`define PRTHF_IRQ_THRESHOLD 0
`define PRTHF_IRQ_DROPPED 1

`define PRTHF_RESET_WORD 32'h0000_0000
`define PRTHF_RESET_HIGH_LIMIT 64'hffff_ffff_ffff_ffff
`define PRTHF_CTL_BITS 2
`define PRTHF_IRQ_BITS 2

`endif

// *** bench/prthf_monitor.sv ***
// port checks for the ring threshold and range filter block
// bound onto prthf_top; one clock, synchronous active-high reset
`timescale 1ns/1ps
module prthf_monitor #(
   parameter RECORD_SIZE = 32
) (
   input wire CLOCK_I,
   input wire RESET_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire PREADY_O,
   input wire PSLVERR_O,
   input wire [31:0] PRDATA_O,
   input wire RECORD_STORED_I,
   input wire EVENT_VALID_I,
   input wire EVENT_COUNT_O,
   input wire [31:0] RING_WRITE_OFFSET_O,
   input wire IRQ_O
);
   // register writes may legally move the offset or the irq
   wire wr_w = PSEL_I && PENABLE_I && PWRITE_I;
   wire cause_w = RECORD_STORED_I || wr_w;
   wire [31:0] wo = RING_WRITE_OFFSET_O;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);
   a_zero_wait: assert property (PREADY_O && !PSLVERR_O) else $error("apb stall or error");
   a_offset_idle: assert property (!RECORD_STORED_I && !wr_w |=> $stable(wo)) else $error("offset moved");
   a_offset_step: assert property (RECORD_STORED_I && !wr_w |=> wo == $past(wo) + RECORD_SIZE || wo == 0 || $stable(wo))
      else $error("bad offset step");
   a_offset_align: assert property (wo % RECORD_SIZE == 0) else $error("offset misaligned");
   a_count_cause: assert property (EVENT_COUNT_O |-> $past(EVENT_VALID_I)) else $error("count without event");
   a_rdata_hold: assert property (!(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O))
      else $error("read data changed");
   a_irq_cause: assert property ($rose(IRQ_O) |-> $past(cause_w) || $past(cause_w, 2))
      else $error("irq without cause");
   a_irq_sticky: assert property (IRQ_O && !wr_w && !$past(wr_w) |=> IRQ_O) else $error("irq fell");
endmodule
bind prthf_top prthf_monitor #(.RECORD_SIZE(RECORD_SIZE)) prthf_monitor_inst (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .PRDATA_O(PRDATA_O), .RECORD_STORED_I(RECORD_STORED_I), .EVENT_VALID_I(EVENT_VALID_I),
   .EVENT_COUNT_O(EVENT_COUNT_O), .RING_WRITE_OFFSET_O(RING_WRITE_OFFSET_O), .IRQ_O(IRQ_O));

// *** bench/prthf_rec_model.sv ***
// record writer model: one strobe per stored record
// same clock as the block; an idle cycle between strobes
`timescale 1ns/1ps
module prthf_rec_model (
   input wire clk_i,
   output logic rec_o
);
   initial rec_o = 1'b0;
   // strobe changes right after an edge only
   task store(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         rec_o <= 1'b1;
         @(posedge clk_i);
         rec_o <= 1'b0;
      end
   endtask
endmodule

// *** bench/prthf_tb_top.sv ***
// self-checking bench for the ring threshold and range filter block
// ring of 0x100 bytes, 32-byte records, apb master tasks
`timescale 1ns/1ps
module prthf_tb_top;
   logic clk, rst, psel, pen, pw, ev_v;
   logic [7:0] pa;
   logic [31:0] pd, ev_c, rd;
   logic [63:0] ev_a;
   wire rec, pready, pslverr, ev_cnt, irq;
   wire [31:0] prdata, wo;
   int n_errors = 0;
   int num_checks = 0;
   // threshold, read offset, records, expected irq
   logic [31:0] rows [7][4] = '{'{32'h0, 32'h0, 32'h1, 32'h1}, '{32'h40, 32'h0, 32'h1, 32'h0},
      '{32'h40, 32'h0, 32'h2, 32'h1}, '{32'h5f, 32'h0, 32'h2, 32'h1}, '{32'h200, 32'h0, 32'h7, 32'h0},
      '{32'h60, 32'he0, 32'h2, 32'h1}, '{32'h80, 32'he0, 32'h2, 32'h0}};
   prthf_top #(.RECORD_SIZE(32)) prthf_top_inst (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pd), .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata),
      .RECORD_STORED_I(rec), .EVENT_VALID_I(ev_v), .EVENT_CLASS_I(ev_c), .EVENT_ADDR_I(ev_a),
      .EVENT_COUNT_O(ev_cnt), .RING_WRITE_OFFSET_O(wo), .IRQ_O(irq));
   prthf_rec_model prthf_rec_model_inst (.clk_i(clk), .rec_o(rec));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task results;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one apb transfer, held until pready is seen high
   task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pen, pw, pa, pd} <= {2'b10, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      {psel, pen} <= 2'b00;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      ap(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      ap(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // irq is sticky, so one extra edge covers either latency
   task irq_is(input logic exp);
      @(posedge clk);
      #1 chk(irq, exp);
   endtask
   task ev(input logic [31:0] c, input logic [63:0] a, input logic exp);
      @(posedge clk);
      {ev_v, ev_c, ev_a} <= {1'b1, c, a};
      @(posedge clk);
      ev_v <= 1'b0;
      #1 chk(ev_cnt, exp);
   endtask
   initial
   begin
      #200us;
      n_errors++;
      results;
   end
   initial
   begin
      {rst, psel, pen, pw, pa, pd, ev_v, ev_c, ev_a} = {1'b1, 140'h0};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h30, 32'hffffffff);
      rdc(8'h20, 32'h0);
      wr(8'h60, 32'h100);
      wr(8'h68, 32'h1);
      wr(8'h78, 32'h3);
      foreach (rows[i])
      begin
         wr(8'h40, rows[i][1]);
         wr(8'h20, rows[i][0]);
         wr(8'h64, 32'h0);
         wr(8'h74, 32'h3);
         prthf_rec_model_inst.store(rows[i][2]);
         irq_is(rows[i][3][0]);
         chk(wo, (rows[i][2] * 32) % 256);
         $display("row %0d end", i);
      end
      // full ring: eighth record is dropped, offset kept
      wr(8'h40, 32'h0);
      wr(8'h64, 32'h0);
      prthf_rec_model_inst.store(8);
      chk(wo, 32'he0);
      rdc(8'h6c, 32'h1);
      wr(8'h78, 32'h0);
      irq_is(1'b0);
      wr(8'h78, 32'h3);
      irq_is(1'b1);
      wr(8'h74, 32'h3);
      irq_is(1'b0);
      // threshold disabled in control
      wr(8'h68, 32'h0);
      wr(8'h20, 32'h0);
      wr(8'h64, 32'h0);
      prthf_rec_model_inst.store(1);
      irq_is(1'b0);
      $display("drop and irq end");
      wr(8'h24, 32'h1);
      wr(8'h28, 32'h100);
      wr(8'h30, 32'h200);
      wr(8'h34, 32'h0);
      wr(8'h68, 32'h2);
      ev(32'h1, 64'hff, 1'b0);
      ev(32'h1, 64'h100, 1'b1);
      ev(32'h1, 64'h200, 1'b1);
      ev(32'h1, 64'h201, 1'b0);
      ev(32'h2, 64'h150, 1'b0);
      wr(8'h68, 32'h0);
      ev(32'h1, 64'h201, 1'b1);
      wr(8'h38, 32'h5a5a5a5a);
      rdc(8'h38, 32'h0);
      rdc(8'h48, 32'h0);
      wr(8'h44, 32'h0);
      rdc(8'h44, 32'h0);
      $display("filter and reserved end");
      results;
   end
endmodule
